// file: rtl/wfce_host.sv
/*
 * Host-side command engine for a 64K x 16 parallel flash: turns one user
 * request into the unlock and command write cycles, then waits for the
 * flash to finish by toggle bit, plus data polling for a program, with a time limit.
 * Assumes the flash is the only load on the pins and dq_i is synchronous.
 */
// Contract
// - Main erase: six cycles, ends 555/30
// - Program is four write cycles
// - Wait program time or poll first
// - Lockout needs six defined command cycles
// - ID mode word 0002 bit0 shows lock
// - Next cycle only after completion seen; on a time-out the engine returns to S_IDLE and takes the next request anyway
// - Every command starts with unlock pair; the short ID exit here sends F0 alone
`timescale 1ns/1ps

module wfce_host
    import wfce_pkg::*;
#(
    parameter int unsigned PROG_TIMEOUT = PROG_TO_CYC,
    parameter int unsigned ERASE_TIMEOUT = ERASE_TO_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire wfce_pkg::wfce_op_t cmd_op,
    input wire logic [wfce_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [wfce_pkg::DATA_W-1:0] cmd_data,
    output logic rsp_valid,
    output logic [wfce_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_timeout,
    output logic [wfce_pkg::ADDR_W-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic [wfce_pkg::DATA_W-1:0] flash_dq_o,
    output logic flash_dq_oe_n,
    input wire logic [wfce_pkg::DATA_W-1:0] flash_dq_i
);
    import wfce_pkg::*;

    typedef enum {S_IDLE, S_ISSUE, S_WAIT, S_RESP} wfce_st_t;

    // Write cycles in each command
    function automatic logic [STEP_W-1:0] seq_len(input wfce_op_t op);
        case (op)
            OP_PROGRAM: seq_len = LEN_PROGRAM;
            OP_CHIP_ERASE, OP_MAIN_ERASE, OP_LOCKOUT: seq_len = LEN_SIX;
            OP_ID_ENTRY, OP_ID_EXIT: seq_len = LEN_THREE;
            OP_ID_EXIT_SHORT: seq_len = LEN_ONE;
            default: seq_len = LEN_NONE;
        endcase
    endfunction

    // Address of a write step; the unlock pair leads except in the one-cycle short ID exit
    function automatic logic [ADDR_W-1:0] step_addr(input wfce_op_t op,
            input logic [STEP_W-1:0] step, input logic [ADDR_W-1:0] ua);
        if (op == OP_ID_EXIT_SHORT) begin
            step_addr = ADDR_ANY;
        end else if (op == OP_PROGRAM && step == 3'h3) begin
            step_addr = ua;
        end else if (step == 3'h1 || step == 3'h4) begin
            step_addr = ADDR_UNLOCK2;
        end else begin
            step_addr = ADDR_UNLOCK1;
        end
    endfunction

    // Data of a write step; command codes leave the upper byte zero as the flash ignores it
    function automatic logic [DATA_W-1:0] step_data(input wfce_op_t op,
            input logic [STEP_W-1:0] step, input logic [DATA_W-1:0] ud);
        logic [7:0] code;
        code = CODE_UNLOCK1;
        case (step)
            3'h0, 3'h3: code = CODE_UNLOCK1;
            3'h1, 3'h4: code = CODE_UNLOCK2;
            3'h2: begin
                case (op)
                    OP_PROGRAM: code = CODE_PROGRAM;
                    OP_ID_ENTRY: code = CODE_ID_ENTRY;
                    OP_ID_EXIT: code = CODE_ID_EXIT;
                    default: code = CODE_ERASE_SETUP;
                endcase
            end
            3'h5: begin
                case (op)
                    OP_CHIP_ERASE: code = CODE_CHIP_ERASE;
                    OP_MAIN_ERASE: code = CODE_MAIN_ERASE;
                    default: code = CODE_LOCKOUT;
                endcase
            end
            default: code = CODE_UNLOCK1;
        endcase
        if (op == OP_ID_EXIT_SHORT) begin
            code = CODE_ID_EXIT;
        end
        step_data = {8'h00, code};
        if (op == OP_PROGRAM && step == 3'h3) begin
            step_data = ud;
        end
    endfunction

    wfce_st_t st_ff, nxt_st;
    wfce_op_t op_ff, nxt_op;
    logic [ADDR_W-1:0] uaddr_ff, nxt_uaddr;
    logic [DATA_W-1:0] udata_ff, nxt_udata;
    logic [STEP_W-1:0] step_ff, nxt_step;
    logic prev_ok_ff, nxt_prev_ok;
    logic prev_tog_ff, nxt_prev_tog;
    logic [31:0] wait_ff, nxt_wait;
    logic ready_ff, nxt_ready;
    logic rsp_valid_ff, nxt_rsp_valid;
    logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
    logic to_ff, nxt_to;
    logic pc_start;
    logic pc_write;
    logic [ADDR_W-1:0] pc_addr;
    logic [DATA_W-1:0] pc_wdata;
    logic pc_done;
    logic [DATA_W-1:0] pc_rdata;
    logic [STEP_W-1:0] cur_len;
    logic needs_wait;
    logic [31:0] wait_limit;
    logic settled;

    // Step decode shared by the cycle request and the completion logic
    always_comb begin
        cur_len = seq_len(op_ff);
        pc_write = step_ff < cur_len;
        pc_start = st_ff == S_ISSUE;
        pc_addr = pc_write ? step_addr(op_ff, step_ff, uaddr_ff) : uaddr_ff;
        pc_wdata = step_data(op_ff, step_ff, udata_ff);
        needs_wait = op_ff inside {OP_PROGRAM, OP_CHIP_ERASE, OP_MAIN_ERASE, OP_LOCKOUT};
        wait_limit = (op_ff == OP_PROGRAM) ? PROG_TIMEOUT : ERASE_TIMEOUT;
        // Done when bit six holds still and, for a program, bit seven matches the written data
        settled = prev_ok_ff && (pc_rdata[BIT_TOGGLE] == prev_tog_ff)
            && (op_ff != OP_PROGRAM || pc_rdata[BIT_POLL] == udata_ff[BIT_POLL]);
    end

    // Command sequencing and completion wait
    always_comb begin
        nxt_st = st_ff;
        nxt_op = op_ff;
        nxt_uaddr = uaddr_ff;
        nxt_udata = udata_ff;
        nxt_step = step_ff;
        nxt_prev_ok = prev_ok_ff;
        nxt_prev_tog = prev_tog_ff;
        nxt_wait = wait_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rsp_data = rsp_data_ff;
        nxt_to = to_ff;
        // Time limit counts from the last write until the flash settles
        if (st_ff != S_IDLE && step_ff == cur_len && needs_wait && wait_ff < wait_limit) begin
            nxt_wait = wait_ff + 32'h1;
        end
        case (st_ff)
            S_IDLE: begin
                if (cmd_valid) begin
                    nxt_st = S_ISSUE;
                    nxt_op = cmd_op;
                    nxt_uaddr = cmd_addr;
                    nxt_udata = cmd_data;
                    nxt_step = '0;
                    nxt_prev_ok = 1'b0;
                    nxt_wait = '0;
                    nxt_to = 1'b0;
                end
            end
            S_ISSUE: begin
                nxt_st = S_WAIT;
            end
            S_WAIT: begin
                if (pc_done && pc_write) begin
                    // Whole sequence sent write after write; no read cycle breaks it, chip select rises for two clocks between writes
                    nxt_step = STEP_W'(step_ff + 3'h1);
                    nxt_st = (nxt_step == cur_len && !needs_wait) ? S_RESP : S_ISSUE;
                end else if (pc_done) begin
                    nxt_rsp_data = pc_rdata;
                    if (!needs_wait || settled) begin
                        nxt_st = S_RESP;
                    end else if (wait_ff >= wait_limit) begin
                        nxt_st = S_RESP;
                        nxt_to = 1'b1;
                    end else begin
                        nxt_st = S_ISSUE;
                        nxt_prev_ok = 1'b1;
                        nxt_prev_tog = pc_rdata[BIT_TOGGLE];
                    end
                end
            end
            S_RESP: begin
                nxt_st = S_IDLE;
                nxt_rsp_valid = 1'b1;
            end
            default: nxt_st = S_IDLE;
        endcase
        // New request only once the engine is back in S_IDLE
        nxt_ready = nxt_st == S_IDLE;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= S_IDLE;
            op_ff <= OP_READ;
            uaddr_ff <= '0;
            udata_ff <= '0;
            step_ff <= '0;
            prev_ok_ff <= 1'b0;
            prev_tog_ff <= 1'b0;
            wait_ff <= '0;
            ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
            to_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            op_ff <= nxt_op;
            uaddr_ff <= nxt_uaddr;
            udata_ff <= nxt_udata;
            step_ff <= nxt_step;
            prev_ok_ff <= nxt_prev_ok;
            prev_tog_ff <= nxt_prev_tog;
            wait_ff <= nxt_wait;
            ready_ff <= nxt_ready;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
            to_ff <= nxt_to;
        end
    end

    assign cmd_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign rsp_timeout = to_ff;

    wfce_pin_cycle u_pin (
        .clock(clock),
        .rst_n(rst_n),
        .start(pc_start),
        .is_write(pc_write),
        .addr(pc_addr),
        .wdata(pc_wdata),
        .done(pc_done),
        .rdata(pc_rdata),
        .addr_pin(flash_addr),
        .ce_n(flash_ce_n),
        .oe_n(flash_oe_n),
        .we_n(flash_we_n),
        .dq_o(flash_dq_o),
        .dq_oe_n(flash_dq_oe_n),
        .dq_i(flash_dq_i)
    );

    default clocking host_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Sequence shape and completion checks
    unlock_first_a: assert property (pc_start && pc_write && step_ff == 3'h0
            && op_ff != OP_ID_EXIT_SHORT |-> pc_addr == 16'h0555 && pc_wdata == 16'h00aa)
        else $error("sequence did not open with first unlock write");
    unlock_second_a: assert property (pc_start && pc_write && step_ff == 3'h1
            |-> pc_addr == 16'h0aaa && pc_wdata == 16'h0055)
        else $error("second unlock write wrong");
    main_erase_end_a: assert property (pc_start && pc_write && op_ff == OP_MAIN_ERASE
            && step_ff == 3'h5 |-> pc_addr == 16'h0555 && pc_wdata == 16'h0030)
        else $error("main erase sixth cycle wrong");
    lockout_end_a: assert property (pc_start && pc_write && op_ff == OP_LOCKOUT
            && step_ff == 3'h5 |-> pc_wdata == 16'h0040)
        else $error("lockout sixth cycle wrong");
    prog_four_a: assert property (pc_start && !pc_write && op_ff == OP_PROGRAM
            |-> step_ff == 3'h4)
        else $error("program poll before four writes");
    busy_not_ready_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready [*3])
        else $error("ready while a command is in flight");
    wait_bound_a: assert property (st_ff == S_WAIT && pc_done && !pc_write && needs_wait
            && !settled && wait_ff >= wait_limit |=> rsp_valid == 1'b0 && to_ff ##1 rsp_valid)
        else $error("time limit not reported");

    prog_done_c: cover property (rsp_valid && op_ff == OP_PROGRAM && !rsp_timeout);
    erase_done_c: cover property (rsp_valid && op_ff == OP_MAIN_ERASE && !rsp_timeout);
    timeout_c: cover property (rsp_valid && rsp_timeout);
    lock_read_c: cover property (rsp_valid && op_ff == OP_READ && uaddr_ff == ADDR_LOCK_STATE);
endmodule

// file: rtl/wfce_pkg.sv
/*
 * Shared constants for the word flash command engine: operation codes,
 * command addresses and codes, status bit positions and pin timing.
 * Assumes a single 250 MHz clock and a 64K x 16 flash on the far side.
 */
package wfce_pkg;

    // Bus shape
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int CNT_W = 4;
    localparam int STEP_W = 3;

    // Clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_MHZ = 250;

    // Operations the user side may request
    typedef enum logic [3:0] {
        OP_READ,
        OP_PROGRAM,
        OP_CHIP_ERASE,
        OP_MAIN_ERASE,
        OP_LOCKOUT,
        OP_ID_ENTRY,
        OP_ID_EXIT,
        OP_ID_EXIT_SHORT
    } wfce_op_t;

    // Command addresses (only the low eleven bits matter in a command cycle), ID lock word and boot block bounds
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 16'h0555;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 16'h0aaa;
    localparam logic [ADDR_W-1:0] ADDR_ANY = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_STATE = 16'h0002;
    localparam logic [ADDR_W-1:0] ADDR_BOOT_FIRST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_BOOT_LAST = 16'h1fff;

    // Command codes, low data byte only
    localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
    localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
    localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
    localparam logic [7:0] CODE_MAIN_ERASE = 8'h30;
    localparam logic [7:0] CODE_LOCKOUT = 8'h40;
    localparam logic [7:0] CODE_PROGRAM = 8'ha0;
    localparam logic [7:0] CODE_ID_ENTRY = 8'h90;
    localparam logic [7:0] CODE_ID_EXIT = 8'hf0;

    // Sequence lengths in write cycles
    localparam logic [STEP_W-1:0] LEN_SIX = 3'h6;
    localparam logic [STEP_W-1:0] LEN_PROGRAM = 3'h4;
    localparam logic [STEP_W-1:0] LEN_THREE = 3'h3;
    localparam logic [STEP_W-1:0] LEN_ONE = 3'h1;
    localparam logic [STEP_W-1:0] LEN_NONE = 3'h0;

    // Status bit positions
    localparam int BIT_POLL = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_LOCK = 0;

    // Pin timing: strobe covers read access and the write pulse width
    localparam int T_STROBE_NS = 45;
    localparam int T_SETUP_NS = 10;
    localparam int T_NOISE_NS = 15;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NOISE_CYC = (T_NOISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Completion time limits before giving up
    localparam int T_PROG_US = 20;
    localparam int T_ERASE_MS = 1500;
    localparam int TO_MARGIN = 4;
    localparam int PROG_TO_CYC = T_PROG_US * CLK_MHZ * TO_MARGIN;
    localparam int ERASE_TO_CYC = T_ERASE_MS * 1000 * CLK_MHZ * TO_MARGIN;

endpackage

// file: rtl/wfce_pin_cycle.sv
/*
 * One flash bus cycle, read or write, on the chip select, output enable,
 * write enable, address and data pins. Every pin comes from a flop.
 * Assumes data inputs are synchronous to clock and settle within the strobe.
 */
`timescale 1ns/1ps

module wfce_pin_cycle
    import wfce_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output logic [ADDR_W-1:0] addr_pin,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe_n,
    input wire logic [DATA_W-1:0] dq_i
);
    import wfce_pkg::*;

    typedef enum {P_IDLE, P_SETUP, P_STROBE, P_HOLD} wfce_pin_st_t;

    localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);

    wfce_pin_st_t st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic wr_ff, nxt_wr;
    logic done_ff, nxt_done;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dq_o_ff, nxt_dq_o;
    logic ce_n_ff, nxt_ce_n;
    logic oe_n_ff, nxt_oe_n;
    logic we_n_ff, nxt_we_n;
    logic dq_oe_n_ff, nxt_dq_oe_n;

    // Phase sequencing; address and data stand still across the whole cycle
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_wr = wr_ff;
        nxt_done = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_addr = addr_ff;
        nxt_dq_o = dq_o_ff;
        nxt_ce_n = ce_n_ff;
        nxt_oe_n = 1'b1;
        nxt_we_n = 1'b1;
        nxt_dq_oe_n = dq_oe_n_ff;
        case (st_ff)
            P_IDLE: begin
                nxt_cnt = '0;
                if (start) begin
                    nxt_st = P_SETUP;
                    nxt_wr = is_write;
                    nxt_addr = addr;
                    nxt_dq_o = wdata;
                    nxt_ce_n = 1'b0;
                    nxt_dq_oe_n = !is_write;
                end
            end
            P_SETUP: begin
                if (cnt_ff == SETUP_LAST) begin
                    nxt_st = P_STROBE;
                    nxt_cnt = '0;
                    // Never both strobes low: reads never program
                    nxt_we_n = !wr_ff;
                    nxt_oe_n = wr_ff;
                end
            end
            P_STROBE: begin
                // Strobe well beyond the noise filter width
                nxt_we_n = !wr_ff;
                nxt_oe_n = wr_ff;
                if (cnt_ff == STROBE_LAST) begin
                    nxt_st = P_HOLD;
                    nxt_cnt = '0;
                    nxt_we_n = 1'b1;
                    nxt_oe_n = 1'b1;
                    if (!wr_ff) begin
                        nxt_rdata = dq_i;
                    end
                end
            end
            P_HOLD: begin
                // Data held past the write enable rise where the flash latches it
                if (cnt_ff == SETUP_LAST) begin
                    nxt_st = P_IDLE;
                    nxt_cnt = '0;
                    nxt_done = 1'b1;
                    nxt_ce_n = 1'b1;
                    nxt_dq_oe_n = 1'b1;
                end
            end
            default: begin
                nxt_st = P_IDLE;
                nxt_ce_n = 1'b1;
                nxt_dq_oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= P_IDLE;
            cnt_ff <= '0;
            wr_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= '0;
            addr_ff <= '0;
            dq_o_ff <= '0;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            dq_oe_n_ff <= 1'b1;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            wr_ff <= nxt_wr;
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
            addr_ff <= nxt_addr;
            dq_o_ff <= nxt_dq_o;
            ce_n_ff <= nxt_ce_n;
            oe_n_ff <= nxt_oe_n;
            we_n_ff <= nxt_we_n;
            dq_oe_n_ff <= nxt_dq_oe_n;
        end
    end

    assign done = done_ff;
    assign rdata = rdata_ff;
    assign addr_pin = addr_ff;
    assign dq_o = dq_o_ff;
    assign ce_n = ce_n_ff;
    assign oe_n = oe_n_ff;
    assign we_n = we_n_ff;
    assign dq_oe_n = dq_oe_n_ff;

    default clocking pin_cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Pin protocol checks
    oe_we_excl_a: assert property (!(!oe_n && !we_n))
        else $error("output enable and write enable low together");
    no_contention_a: assert property (!oe_n |-> dq_oe_n)
        else $error("data driven while flash outputs enabled");
    we_width_a: assert property ($fell(we_n) |-> !we_n [*4])
        else $error("write enable pulse too short for noise filter");
    addr_stable_a: assert property (!we_n || !oe_n |=> $stable(addr_pin))
        else $error("address moved during a strobe");
    data_stable_a: assert property ($rose(we_n) |-> !dq_oe_n && !ce_n && $stable(dq_o))
        else $error("write data not held at write enable rise");
endmodule

// file: sim/wfce_flash_model.sv
/* Behavioural 64K x 16 flash for the engine bench.
 * Assumes engine pins and a data bus resolved by the bench. */
`timescale 1ns/1ps

module wfce_flash_model
    import wfce_pkg::*;
#(
    parameter logic [15:0] MFR_CODE = 16'h00a5 // Arbitrary value
) (
    input wire logic [15:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    input wire logic [31:0] prog_ns
);
    logic [15:0] mem [0:65535];
    logic [15:0] la;
    logic [2:0] step = 3'h0;
    logic lock = 1'b0, id = 1'b0, pp = 1'b0, tog = 1'b0, rd_on = 1'b0, pol = 1'b0;
    realtime busy_end = 0, t_fall = 0;

    // Parts leave the factory erased
    initial begin
        dq_out = 16'h0;
        foreach (mem[i]) mem[i] = 16'hffff;
    end

    // Address at the falling strobe, data at the rising one
    always @(negedge we_n) begin
        t_fall = $realtime;
        la = addr;
    end
    // Glitches, read-enabled writes and writes while busy are dropped
    always @(posedge we_n)
        if (!ce_n && oe_n && $realtime - t_fall >= T_NOISE_NS && $realtime >= busy_end)
            take(la, dq_in);

    // Command decoder; low address bits and low data byte only
    task automatic take(input logic [15:0] a, input logic [15:0] d);
        logic [10:0] c;
        logic [7:0] lo;
        c = a[10:0];
        lo = d[7:0];
        if (pp) begin
            if (!lock || a > ADDR_BOOT_LAST) mem[a] = mem[a] & d;
            pol = d[7];
            pp = 1'b0;
            busy_end = $realtime + prog_ns;
        end else if (step == 3'h0 && lo == CODE_ID_EXIT) id = 1'b0;
        else case (step)
            3'h0, 3'h3: step = (c == 11'h555 && lo == CODE_UNLOCK1) ? step + 3'h1 : 3'h0;
            3'h1, 3'h4: step = (c == 11'h2aa && lo == CODE_UNLOCK2) ? step + 3'h1 : 3'h0;
            3'h2: begin
                step = (c == 11'h555 && lo == CODE_ERASE_SETUP) ? 3'h3 : 3'h0;
                pp = c == 11'h555 && lo == CODE_PROGRAM;
                if (c == 11'h555 && lo == CODE_ID_ENTRY) id = 1'b1;
                if (c == 11'h555 && lo == CODE_ID_EXIT) id = 1'b0;
            end
            default: begin
                step = 3'h0;
                if (c == 11'h555 && lo == CODE_LOCKOUT) lock = 1'b1;
                if (c == 11'h555 && (lo == CODE_CHIP_ERASE || lo == CODE_MAIN_ERASE)) begin
                    for (int i = 0; i < 65536; i++)
                        if (i > ADDR_BOOT_LAST || (lo == CODE_CHIP_ERASE && !lock))
                            mem[i] = 16'hffff;
                    pol = 1'b1;
                    busy_end = $realtime + 2000;
                end
            end
        endcase
    endtask

    // Status while busy; a released bus shows a moving pattern
    always @(addr, ce_n, oe_n, we_n) begin
        if (!ce_n && !oe_n && we_n) begin
            if ($realtime < busy_end) begin
                tog = rd_on ? tog : ~tog;
                dq_out = 16'h0;
                dq_out[BIT_POLL] = ~pol;
                dq_out[BIT_TOGGLE] = tog;
            end else if (id)
                dq_out = (addr == 16'h0) ? MFR_CODE : {15'h0, lock};
            else
                dq_out = mem[addr];
            rd_on = 1'b1;
        end else begin
            rd_on = 1'b0;
            dq_out = ~dq_out;
        end
    end
endmodule

// file: sim/wfce_host_bench.sv
/* Self-checking bench for the flash command engine.
 * Assumes the behavioural flash model beside it. */
`timescale 1ns/1ps

module wfce_host_bench
    import wfce_pkg::*;
;
    localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    wfce_op_t cmd_op = OP_READ;
    logic [15:0] cmd_addr = 16'h0, cmd_data = 16'h0, rsp_data, f_addr, dq_o, dq_f, rd, a, d;
    logic cmd_ready, rsp_valid, rsp_timeout, ce_n, oe_n, we_n, dq_oe_n;
    logic [31:0] prog_ns = 32'd400;
    int err_total = 0, samples_checked = 0, n;
    wire [15:0] dq_bus = dq_oe_n ? dq_f : dq_o; // Engine wins while driving

    always #2 clock = ~clock;

    wfce_host #(.PROG_TIMEOUT(2000), .ERASE_TIMEOUT(3000)) dut (.clock(clock), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_timeout(rsp_timeout), .flash_addr(f_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_bus));
    wfce_flash_model #(.MFR_CODE(MAKER)) flash (.addr(f_addr), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .dq_in(dq_bus), .dq_out(dq_f), .prog_ns(prog_ns));

    task automatic stop_test();
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input string what, input logic exp, input logic got);
        chk_word(what, {15'h0, exp}, {15'h0, got});
    endtask

    // Program can only clear bits
    function automatic logic [15:0] after_prog(input logic [15:0] old, input logic [15:0] nw);
        return old & nw;
    endfunction

    // One request, held until taken; bounded wait for the answer
    task automatic run(input wfce_op_t op, input logic [15:0] ad, input logic [15:0] dt,
        input logic exp_to);
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_data <= dt;
        cmd_valid <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (cmd_ready !== 1'b1 && n < 200);
        if (n >= 200) begin
            err_total++;
            stop_test();
        end
        cmd_valid <= 1'b0;
        do begin @(posedge clock); n++; end while (rsp_valid !== 1'b1 && n < 8000);
        if (n >= 8000) begin
            err_total++;
            stop_test();
        end
        rd = rsp_data;
        chk_flag("timeout", exp_to, rsp_timeout);
    endtask

    initial begin
        void'($urandom(32'h41e32061));
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        run(OP_READ, 16'($urandom), 16'h0, 1'b0);
        chk_word("erased", 16'hffff, rd);
        // Random words in main memory, then a second pass
        for (int i = 0; i < 6; i++) begin
            a = 16'h2000 + 16'(i * 256) + 16'($urandom_range(255));
            d = 16'($urandom);
            run(OP_PROGRAM, a, d, 1'b0);
            // Bit seven kept low: a one over a stored zero never polls true
            run(OP_PROGRAM, a, 16'($urandom) & 16'hff7f, 1'b0);
            d = after_prog(d, cmd_data);
            run(OP_READ, a, 16'h0, 1'b0);
            chk_word("program", d, rd);
        end
        // Unlocked chip erase reaches the boot block edge
        run(OP_PROGRAM, ADDR_BOOT_LAST, 16'h00f0, 1'b0);
        run(OP_CHIP_ERASE, 16'h2000, 16'h0, 1'b0);
        run(OP_READ, ADDR_BOOT_LAST, 16'h0, 1'b0);
        chk_word("boot erased", 16'hffff, rd);
        run(OP_READ, a, 16'h0, 1'b0);
        chk_word("main erased", 16'hffff, rd);
        run(OP_ID_ENTRY, 16'h0, 16'h0, 1'b0);
        run(OP_READ, ADDR_LOCK_STATE, 16'h0, 1'b0);
        chk_flag("lock clear", 1'b0, rd[BIT_LOCK]);
        run(OP_READ, ADDR_ANY, 16'h0, 1'b0);
        chk_word("maker", MAKER, rd);
        run(OP_ID_EXIT_SHORT, 16'h0, 16'h0, 1'b0);
        run(OP_READ, ADDR_LOCK_STATE, 16'h0, 1'b0);
        chk_word("short exit", 16'hffff, rd);
        // Lock the boot block, then try to change it
        run(OP_PROGRAM, ADDR_BOOT_LAST, 16'h1234, 1'b0);
        run(OP_LOCKOUT, 16'h2000, 16'h0, 1'b0);
        run(OP_ID_ENTRY, 16'h0, 16'h0, 1'b0);
        run(OP_READ, ADDR_LOCK_STATE, 16'h0, 1'b0);
        chk_flag("lock set", 1'b1, rd[BIT_LOCK]);
        run(OP_ID_EXIT, 16'h0, 16'h0, 1'b0);
        run(OP_PROGRAM, ADDR_BOOT_LAST, 16'h0000, 1'b0);
        run(OP_READ, ADDR_BOOT_LAST, 16'h0, 1'b0);
        chk_word("boot kept", 16'h1234, rd);
        run(OP_PROGRAM, 16'h2000, 16'h00ff, 1'b0);
        run(OP_READ, 16'h2000, 16'h0, 1'b0);
        chk_word("main program", 16'h00ff, rd);
        run(OP_MAIN_ERASE, 16'h2000, 16'h0, 1'b0);
        run(OP_READ, 16'h2000, 16'h0, 1'b0);
        chk_word("main erase", 16'hffff, rd);
        run(OP_CHIP_ERASE, 16'h2000, 16'h0, 1'b0);
        run(OP_READ, ADDR_BOOT_LAST, 16'h0, 1'b0);
        chk_word("locked erase", 16'h1234, rd);
        // A flash that settles only after 40000 ns, five times the 2000-cycle limit, must be given up on
        prog_ns <= 32'd40000;
        run(OP_PROGRAM, 16'h3000, 16'h0f0f, 1'b1);
        stop_test();
    end
endmodule
